// ===== logic/chan_seq_pkg.sv
package chan_seq_pkg;

  // ----------------------------------------
  // Word layout (vector index = 35 - bit)
  // ----------------------------------------
  localparam int WORD_W = 36;
  localparam int HALF_W = 18;
  localparam int LEFT_LSB = 18;
  localparam int FIRST_PTR_LSB = 1;
  localparam int FIRST_PTR_MSB = 8;
  localparam int FIRST_PTR_W = 8;
  localparam int PTR_LOAD_ZERO_LSB = 17;

  // ----------------------------------------
  // Reset values and step increment
  // ----------------------------------------
  localparam logic [35:0] WORD_ZERO = 36'h000000000;
  localparam logic [17:0] HALF_ZERO = 18'h00000;
  localparam logic [17:0] HALF_ONE = 18'h00001;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int DELAY_W = 8;
  localparam int CLK_PERIOD_NS = 40;
  localparam int START_DELAY_NS = 50;
  localparam logic [7:0] START_DELAY_CYC =
    8'((START_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] PTR_XFER_CYC = 8'h02;
  localparam logic [7:0] READ_SETTLE_CYC = 8'h02;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_START,
    ST_WAIT_PTR,
    ST_PTR_XFER,
    ST_FETCH,
    ST_MEM,
    ST_SETTLE,
    ST_SYNC_OFF,
    ST_EVAL,
    ST_DATA
  } seq_state_e;

endpackage

// ===== logic/desc_eval_if.sv
`timescale 1ns/1ns
// Buffer word out, descriptor decode back
interface desc_eval_if;
  logic [35:0] word;
  logic par;
  logic count_zero;
  logic pointer_zero;
  logic parity_err;
  logic pointer_word_ok;
  modport src (output word, output par, input count_zero,
    input pointer_zero, input parity_err, input pointer_word_ok);
  modport eval (input word, input par, output count_zero,
    output pointer_zero, output parity_err, output pointer_word_ok);
endinterface

// ===== logic/desc_eval.sv
`timescale 1ns/1ns
module desc_eval (
  desc_eval_if.eval bus
);
  import chan_seq_pkg::*;

  // Zero and odd-parity detection on the buffer
  always_comb begin
    bus.count_zero = (bus.word[WORD_W-1:LEFT_LSB] == HALF_ZERO);
    bus.pointer_zero = (bus.word[HALF_W-1:0] == HALF_ZERO);
    bus.parity_err = ~(^{bus.word, bus.par});
    bus.pointer_word_ok = (bus.word[WORD_W-1:PTR_LOAD_ZERO_LSB] == 19'h00000);
  end
endmodule

// ===== logic/settle_timer.sv
`timescale 1ns/1ns
module settle_timer (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Control
  input wire logic i_start,
  input wire logic [chan_seq_pkg::DELAY_W-1:0] i_cycles,
  output logic o_done
);
  import chan_seq_pkg::*;

  logic [DELAY_W-1:0] remain;

  // Count down, pulse done on the last cycle
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      remain <= BYTE_ZERO;
      o_done <= 1'b0;
    end else if (i_start) begin
      remain <= i_cycles;
      o_done <= 1'b0;
    end else begin
      o_done <= (remain == 8'h01);
      if (remain != BYTE_ZERO) begin
        remain <= remain - 8'h01;
      end
    end
  end
endmodule

// ===== logic/descriptor_channel_sequencer.sv
`timescale 1ns/1ns
// What this block does
// R1 - Access request clears idle, raises grant, then awaits first pointer
// R2 - Request clears stop latch; start pulse later clears idle and buffer
// R3 - Peripheral sends first pointer on bits 27-34 with peer strobe
// R4 - Peripheral holds bits 0-18 zero in the first pointer word
// R5 - Direction select captured into memory write direction flag at setup
// R6 - Pointer word with zero left half loads descriptor pointer, clears buffer
// R7 - Pointer load sets fetch request; fetch clears count, sets cycle flag
// R8 - Cycle flag requests mux; on grant drive pointer address, read cycle
// R9 - Cycle request on flag, grant, none pending; first latches pointer
// R10 - Address accepted sets withdrawn flag, dropping cycle request
// R11 - Read return fills buffer; after settle end cycle, clear fetch
// R12 - Cycle flag drops only once all transfer requests are inactive
// R13 - Descriptor parity error sets idle and signals the peripheral
// R14 - All-zero descriptor sets idle and withdraws grant
// R15 - Zero count, nonzero pointer: jump to pointer, fetch next
// R16 - Nonzero count loads count, and transfer pointer if nonzero, from buffer
// R17 - Zero pointer sets discard: words accepted, none written
// R18 - Count and pointer step per word; overflow fetches next descriptor
// R19 - Descriptor pointer steps once after evaluation
// R20 - First memory word goes straight out; setup strobe meant ready
// R21 - Empty buffer starts a read; full buffer waits for peer strobe
// R22 - Count zero and buffer empty fetches next descriptor
// R23 - Peer strobe word written, counters stepped, then host strobe
// R24 - Channel reset forces the whole sequencer clear
// R25 - Peripheral waits 400 ns after grant falls before re-requesting
// R26 - Every settle delay is a programmable count of clock cycles
module descriptor_channel_sequencer #(
  parameter logic [7:0] START_CYC = chan_seq_pkg::START_DELAY_CYC,
  parameter logic [7:0] XFER_CYC = chan_seq_pkg::PTR_XFER_CYC,
  parameter logic [7:0] SETTLE_CYC = chan_seq_pkg::READ_SETTLE_CYC
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Peripheral control
  input wire logic i_chan_reset,
  input wire logic i_access_req,
  input wire logic i_dir_to_periph,
  input wire logic i_peer_strobe,
  input wire logic [chan_seq_pkg::WORD_W-1:0] i_periph_data,
  output logic o_access_grant,
  output logic o_idle,
  output logic o_host_strobe,
  output logic [chan_seq_pkg::WORD_W-1:0] o_periph_data,
  output logic o_descriptor_parity_error,
  output logic [chan_seq_pkg::FIRST_PTR_W-1:0] o_first_pointer,
  // Memory multiplexor port
  output logic o_mux_request,
  input wire logic i_mux_grant,
  output logic o_cycle_request,
  output logic o_mem_read,
  output logic o_mem_write,
  output logic [chan_seq_pkg::HALF_W-1:0] o_mem_addr,
  output logic [chan_seq_pkg::WORD_W-1:0] o_mem_wdata,
  input wire logic i_address_accepted,
  input wire logic i_read_return,
  input wire logic [chan_seq_pkg::WORD_W-1:0] i_mem_rdata,
  input wire logic i_mem_rparity
);
  import chan_seq_pkg::*;

  // ----------------------------------------
  // Parameter checks
  // ----------------------------------------
  if (START_CYC == BYTE_ZERO || XFER_CYC == BYTE_ZERO ||
      SETTLE_CYC == BYTE_ZERO) begin : g_bad_delay
    $error("settle delays must be at least one cycle");
  end

  function automatic logic [17:0] step(input logic [17:0] v);
    return v + HALF_ONE;
  endfunction

  // ----------------------------------------
  // State and registers
  // ----------------------------------------
  seq_state_e state;
  logic clear;
  logic req_d;
  logic stop_latch;
  logic memory_write_direction;
  logic [35:0] transfer_buffer;
  logic buffer_par;
  logic buffer_full;
  logic periph_ready;
  logic [17:0] descriptor_pointer;
  logic [17:0] remaining_count;
  logic [17:0] transfer_pointer;
  logic discard_flag;
  logic descriptor_fetch_request;
  logic descriptor_fetch_active;
  logic word_transfer_request;
  logic memory_cycle_flag;
  logic request_withdrawn;
  logic first_pointer_latched;
  logic eval_pending;
  logic tmr_start;
  logic [7:0] tmr_cycles;
  logic tmr_done;
  logic descriptor_writeback;
  desc_eval_if dbus ();

  // Pulses decoded from state and inputs
  logic start_pulse;
  logic ptr_load;
  logic ptr_bad;
  logic req_go;
  logic addr_ack;
  logic rd_ret;
  logic settle_done;
  logic eval_jump;
  logic eval_stop;
  logic eval_data;
  logic fetch_go;
  logic hand_word;
  logic skip_word;
  logic write_word;
  logic read_word;
  logic abort;

  assign clear = !i_rst_n || i_chan_reset; // [R24]
  assign descriptor_writeback = 1'b0;
  assign dbus.word = transfer_buffer;
  assign dbus.par = buffer_par;
  assign o_mux_request = memory_cycle_flag; // [R8]

  always_comb begin
    start_pulse = (state == ST_IDLE) && i_access_req && !req_d; // [R2]
    ptr_load = (state == ST_PTR_XFER) && tmr_done && dbus.pointer_word_ok;
    ptr_bad = (state == ST_PTR_XFER) && tmr_done && !dbus.pointer_word_ok;
    req_go = memory_cycle_flag && i_mux_grant && !o_cycle_request &&
      !request_withdrawn; // [R9]
    addr_ack = (state == ST_MEM) && o_cycle_request && i_address_accepted;
    rd_ret = (state == ST_MEM) && request_withdrawn && i_read_return &&
      !o_mem_write;
    settle_done = (state == ST_SETTLE) && tmr_done;
    eval_stop = (state == ST_EVAL) && (dbus.parity_err ||
      (dbus.count_zero && dbus.pointer_zero)); // [R13] [R14]
    eval_jump = (state == ST_EVAL) && !eval_stop && dbus.count_zero; // [R15]
    eval_data = (state == ST_EVAL) && !eval_stop && !dbus.count_zero;
    fetch_go = (state == ST_DATA) && !buffer_full &&
      (remaining_count == HALF_ZERO); // [R18] [R22]
    hand_word = (state == ST_DATA) && !memory_write_direction &&
      buffer_full && periph_ready; // [R20] [R21]
    read_word = (state == ST_DATA) && !memory_write_direction &&
      !buffer_full && !fetch_go; // [R21]
    skip_word = (state == ST_DATA) && memory_write_direction &&
      !fetch_go && i_peer_strobe && discard_flag; // [R17]
    write_word = (state == ST_DATA) && memory_write_direction &&
      !fetch_go && i_peer_strobe && !discard_flag; // [R23]
    abort = !i_access_req && ((state == ST_WAIT_PTR) ||
      (state == ST_DATA));
  end

  // ----------------------------------------
  // Sub-blocks
  // ----------------------------------------
  desc_eval u_eval (
    .bus (dbus)
  );

  settle_timer u_timer (
    .i_sys_clk (i_sys_clk),
    .i_rst_n (!clear),
    .i_start (tmr_start),
    .i_cycles (tmr_cycles),
    .o_done (tmr_done)
  );

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Main state walk and delay launches
  always_ff @(posedge i_sys_clk) begin
    if (clear) begin
      state <= ST_IDLE;
      tmr_start <= 1'b0;
      tmr_cycles <= BYTE_ZERO;
      eval_pending <= 1'b0;
    end else begin
      tmr_start <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start_pulse) begin
            state <= ST_START;
            tmr_start <= 1'b1; // [R26]
            tmr_cycles <= START_CYC;
          end
        end
        ST_START: begin
          if (tmr_done) begin
            state <= ST_WAIT_PTR; // [R1]
          end
        end
        ST_WAIT_PTR: begin
          if (abort) begin
            state <= ST_IDLE;
          end else if (i_peer_strobe) begin
            state <= ST_PTR_XFER; // [R3]
            tmr_start <= 1'b1;
            tmr_cycles <= XFER_CYC;
          end
        end
        ST_PTR_XFER: begin
          if (ptr_load) begin
            state <= ST_FETCH; // [R6]
          end else if (ptr_bad) begin
            state <= ST_IDLE;
          end
        end
        ST_FETCH: begin
          state <= ST_MEM; // [R7]
          eval_pending <= 1'b1;
        end
        ST_MEM: begin
          if (rd_ret) begin
            state <= ST_SETTLE; // [R11]
            tmr_start <= 1'b1;
            tmr_cycles <= SETTLE_CYC;
          end else if (addr_ack && o_mem_write) begin
            state <= ST_SYNC_OFF;
          end
        end
        ST_SETTLE: begin
          if (settle_done) begin
            state <= ST_SYNC_OFF;
          end
        end
        ST_SYNC_OFF: begin
          if (!descriptor_fetch_request && !descriptor_fetch_active &&
              !word_transfer_request && !descriptor_writeback) begin
            state <= eval_pending ? ST_EVAL : ST_DATA; // [R12]
            eval_pending <= 1'b0;
          end
        end
        ST_EVAL: begin
          if (eval_stop) begin
            state <= ST_IDLE;
          end else if (eval_jump) begin
            state <= ST_FETCH; // [R15]
          end else begin
            state <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (abort) begin
            state <= ST_IDLE;
          end else if (fetch_go) begin
            state <= ST_FETCH; // [R18]
          end else if (read_word || write_word) begin
            state <= ST_MEM;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Idle, grant, stop latch and error pulse
  always_ff @(posedge i_sys_clk) begin
    if (clear) begin
      o_idle <= 1'b1;
      o_access_grant <= 1'b0;
      stop_latch <= 1'b0;
      req_d <= 1'b0;
      o_descriptor_parity_error <= 1'b0;
    end else begin
      req_d <= i_access_req;
      o_descriptor_parity_error <= (state == ST_EVAL) &&
        dbus.parity_err; // [R13]
      if (start_pulse) begin
        stop_latch <= 1'b0; // [R2]
      end
      if ((state == ST_START) && tmr_done) begin
        o_idle <= 1'b0; // [R1] [R2]
        o_access_grant <= 1'b1;
      end else if (eval_stop || ptr_bad || abort) begin
        o_idle <= 1'b1; // [R13] [R14]
        o_access_grant <= 1'b0;
        stop_latch <= 1'b1;
      end
    end
  end

  // Direction captured during setup
  always_ff @(posedge i_sys_clk) begin
    if (clear) begin
      memory_write_direction <= 1'b0;
    end else if ((state == ST_START) || (state == ST_WAIT_PTR)) begin
      memory_write_direction <= !i_dir_to_periph; // [R5]
    end
  end

  // ----------------------------------------
  // Transfer buffer
  // ----------------------------------------
  // Fill, clear and full flag
  always_ff @(posedge i_sys_clk) begin
    if (clear) begin
      transfer_buffer <= WORD_ZERO;
      buffer_par <= 1'b1;
      buffer_full <= 1'b0;
    end else begin
      if (((state == ST_START) && tmr_done) || ptr_load || eval_data ||
          skip_word || hand_word || (addr_ack && o_mem_write)) begin
        transfer_buffer <= WORD_ZERO; // [R2] [R6] [R23]
        buffer_par <= 1'b1;
        buffer_full <= 1'b0;
      end else if (((state == ST_WAIT_PTR) && i_peer_strobe) ||
          write_word) begin
        transfer_buffer <= i_periph_data; // [R3]
      end else if (rd_ret) begin
        transfer_buffer <= i_mem_rdata; // [R11]
        buffer_par <= i_mem_rparity;
      end
      if (settle_done && !eval_pending) begin
        buffer_full <= 1'b1;
      end
    end
  end

  // Peripheral readiness; the setup strobe counts as ready
  always_ff @(posedge i_sys_clk) begin
    if (clear) begin
      periph_ready <= 1'b0;
    end else if (((state != ST_WAIT_PTR) && i_peer_strobe) || ptr_load) begin
      periph_ready <= 1'b1; // [R20] [R21]
    end else if (hand_word) begin
      periph_ready <= 1'b0;
    end
  end

  // Word and strobe toward the peripheral
  always_ff @(posedge i_sys_clk) begin
    if (clear) begin
      o_host_strobe <= 1'b0;
      o_periph_data <= WORD_ZERO;
    end else begin
      o_host_strobe <= hand_word || skip_word ||
        (addr_ack && o_mem_write); // [R23]
      if (hand_word) begin
        o_periph_data <= transfer_buffer; // [R20]
      end
    end
  end

  // ----------------------------------------
  // Pointers and count
  // ----------------------------------------
  // Descriptor pointer: first load, jump, step
  always_ff @(posedge i_sys_clk) begin
    if (clear) begin
      descriptor_pointer <= HALF_ZERO;
    end else if (ptr_load || eval_jump) begin
      descriptor_pointer <= transfer_buffer[HALF_W-1:0]; // [R6] [R15]
    end else if (eval_data) begin
      descriptor_pointer <= step(descriptor_pointer); // [R19]
    end
  end

  // Count, transfer pointer and discard flag
  always_ff @(posedge i_sys_clk) begin
    if (clear) begin
      remaining_count <= HALF_ZERO;
      transfer_pointer <= HALF_ZERO;
      discard_flag <= 1'b0;
    end else if (state == ST_FETCH) begin
      remaining_count <= HALF_ZERO; // [R7]
    end else if (eval_data) begin
      remaining_count <= transfer_buffer[WORD_W-1:LEFT_LSB]; // [R16]
      discard_flag <= dbus.pointer_zero; // [R17]
      if (!dbus.pointer_zero) begin
        transfer_pointer <= transfer_buffer[HALF_W-1:0]; // [R16]
      end
    end else if (skip_word ||
        (addr_ack && !descriptor_fetch_active)) begin
      remaining_count <= step(remaining_count); // [R18]
      transfer_pointer <= step(transfer_pointer);
    end
  end

  // ----------------------------------------
  // Memory cycle control
  // ----------------------------------------
  // Fetch and transfer requests, cycle flag
  always_ff @(posedge i_sys_clk) begin
    if (clear) begin
      descriptor_fetch_request <= 1'b0;
      descriptor_fetch_active <= 1'b0;
      word_transfer_request <= 1'b0;
      memory_cycle_flag <= 1'b0;
    end else begin
      if (ptr_load || eval_jump || fetch_go) begin
        descriptor_fetch_request <= 1'b1; // [R7] [R15]
      end else if (state == ST_FETCH) begin
        descriptor_fetch_request <= 1'b0;
        descriptor_fetch_active <= 1'b1;
        memory_cycle_flag <= 1'b1; // [R7]
      end
      if (read_word || write_word) begin
        word_transfer_request <= 1'b1;
        memory_cycle_flag <= 1'b1;
      end
      if (settle_done || (addr_ack && o_mem_write)) begin
        descriptor_fetch_active <= 1'b0; // [R11]
        word_transfer_request <= 1'b0;
      end
      if ((state == ST_SYNC_OFF) && !descriptor_fetch_request &&
          !descriptor_fetch_active && !word_transfer_request &&
          !descriptor_writeback) begin
        memory_cycle_flag <= 1'b0; // [R12]
      end
    end
  end

  // Cycle request, withdrawal and address phase
  always_ff @(posedge i_sys_clk) begin
    if (clear) begin
      o_cycle_request <= 1'b0;
      request_withdrawn <= 1'b0;
      o_mem_read <= 1'b0;
      o_mem_write <= 1'b0;
      o_mem_addr <= HALF_ZERO;
      o_mem_wdata <= WORD_ZERO;
    end else if (req_go) begin
      o_cycle_request <= 1'b1; // [R9]
      o_mem_read <= !word_transfer_request || !memory_write_direction;
      o_mem_write <= word_transfer_request && memory_write_direction;
      o_mem_addr <= descriptor_fetch_active ? descriptor_pointer :
        transfer_pointer; // [R8]
      o_mem_wdata <= transfer_buffer;
    end else if (addr_ack) begin
      o_cycle_request <= 1'b0; // [R10]
      request_withdrawn <= 1'b1;
    end else if (!memory_cycle_flag) begin
      // Cycle flag is down: arm for the next request
      request_withdrawn <= 1'b0;
      o_mem_read <= 1'b0;
      o_mem_write <= 1'b0;
    end
  end

  // First pointer bits caught on the first cycle request
  always_ff @(posedge i_sys_clk) begin
    if (clear || start_pulse) begin
      first_pointer_latched <= 1'b0;
      o_first_pointer <= BYTE_ZERO;
    end else if (req_go && !first_pointer_latched) begin
      first_pointer_latched <= 1'b1; // [R9]
      o_first_pointer <=
        descriptor_pointer[FIRST_PTR_MSB:FIRST_PTR_LSB];
    end
  end

endmodule

// ===== verification/descriptor_channel_sequencer_props.sv
`timescale 1ns/1ns
module descriptor_channel_sequencer_props (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Watched inputs
  input wire logic i_chan_reset,
  input wire logic i_access_req,
  input wire logic i_mux_grant,
  input wire logic i_address_accepted,
  // Watched outputs
  input wire logic o_access_grant,
  input wire logic o_idle,
  input wire logic o_host_strobe,
  input wire logic o_descriptor_parity_error,
  input wire logic o_mux_request,
  input wire logic o_cycle_request,
  input wire logic o_mem_read,
  input wire logic o_mem_write
);
  // ------
  // Sequencer properties
  // ------
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n || i_chan_reset);

  grant_follows_req_a: assert property (
    $rose(i_access_req) && o_idle |-> ##[2:8] (o_access_grant && !o_idle))
    else $error("grant missing after request");
  grant_not_idle_a: assert property (
    o_access_grant |-> !o_idle) else $error("grant while idle");
  reset_clears_a: assert property (disable iff (!i_rst_n)
    i_chan_reset |=> o_idle && !o_access_grant && !o_mux_request)
    else $error("channel reset left state");
  request_on_grant_a: assert property (
    $rose(o_cycle_request) |-> $past(o_mux_request && i_mux_grant))
    else $error("cycle request without mux grant");
  request_drop_a: assert property (
    o_cycle_request && i_address_accepted |=> !o_cycle_request)
    else $error("cycle request not withdrawn");
  request_hold_a: assert property (
    o_cycle_request && !i_address_accepted |=> o_cycle_request)
    else $error("cycle request dropped early");
  one_kind_a: assert property (
    o_cycle_request |-> o_mem_read != o_mem_write)
    else $error("cycle kind unclear");
  sync_covers_a: assert property (
    o_cycle_request |-> o_mux_request) else $error("sync dropped early");
  parity_stop_a: assert property (
    o_descriptor_parity_error |-> ##[0:3] (o_idle && !o_access_grant))
    else $error("parity error did not stop");
  strobe_single_a: assert property (
    o_host_strobe |=> !o_host_strobe) else $error("host strobe too long");
endmodule

// ===== verification/mux_memory_model.sv
`timescale 1ns/1ns
module mux_memory_model (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Channel memory port
  input wire logic i_mux_request,
  input wire logic i_cycle_request,
  input wire logic i_mem_read,
  input wire logic [17:0] i_mem_addr,
  input wire logic [35:0] i_mem_wdata,
  output logic o_mux_grant,
  output logic o_address_accepted,
  output logic o_read_return,
  output logic [35:0] o_mem_rdata,
  output logic o_mem_rparity
);
  logic [35:0] mem [0:255];
  logic [17:0] bad_addr;
  logic [17:0] rd_addr;
  logic [1:0] rd_wait;

  // Slow grant, accept at most every other cycle, read data three cycles after accept
  always @(posedge i_sys_clk) begin
    o_mux_grant <= i_rst_n && i_mux_request;
    o_address_accepted <= i_rst_n && i_cycle_request &&
      !o_address_accepted;
    o_read_return <= 1'b0;
    o_mem_rdata <= ~o_mem_rdata; // Released lines keep toggling
    o_mem_rparity <= ~o_mem_rparity;
    if (!i_rst_n) begin
      rd_wait <= 2'h0;
      o_mem_rdata <= 36'h000000000;
      o_mem_rparity <= 1'b0;
    end else if (rd_wait == 2'h1) begin
      o_read_return <= 1'b1;
      o_mem_rdata <= mem[rd_addr[7:0]];
      o_mem_rparity <= ~(^mem[rd_addr[7:0]]) ^ (rd_addr == bad_addr);
    end
    if (rd_wait != 2'h0) begin
      rd_wait <= rd_wait - 2'h1;
    end
    if (i_rst_n && o_address_accepted && i_mem_read) begin
      rd_wait <= 2'h2;
      rd_addr <= i_mem_addr;
    end
    if (i_rst_n && o_address_accepted && !i_mem_read) begin
      mem[i_mem_addr[7:0]] <= i_mem_wdata;
    end
  end
endmodule

// ===== verification/descriptor_channel_sequencer_tb.sv
`timescale 1ns/1ns
module descriptor_channel_sequencer_tb;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_chan_reset = 1'b0;
  logic i_access_req = 1'b0;
  logic i_dir_to_periph = 1'b0;
  logic i_peer_strobe = 1'b0;
  logic [35:0] i_periph_data = 36'h000000000;
  logic o_access_grant, o_idle, o_host_strobe, o_descriptor_parity_error;
  logic o_mux_request, i_mux_grant, o_cycle_request, o_mem_read;
  logic o_mem_write, i_address_accepted, i_read_return, i_mem_rparity;
  logic [7:0] o_first_pointer;
  logic [17:0] o_mem_addr;
  logic [35:0] o_periph_data, o_mem_wdata, i_mem_rdata;
  int errors = 0;
  int checks = 0;
  int cycles = 0;

  // ------
  // Design and memory side
  // ------
  always #20 i_sys_clk = ~i_sys_clk;
  descriptor_channel_sequencer i_dut (.*);
  mux_memory_model i_mem (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_mux_request(o_mux_request), .i_cycle_request(o_cycle_request),
    .i_mem_read(o_mem_read), .i_mem_addr(o_mem_addr),
    .i_mem_wdata(o_mem_wdata), .o_mux_grant(i_mux_grant),
    .o_address_accepted(i_address_accepted),
    .o_read_return(i_read_return), .o_mem_rdata(i_mem_rdata),
    .o_mem_rparity(i_mem_rparity));

  // ------
  // Tasks
  // ------
  task automatic test_done();
    if (errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask

  // Wait for host strobe, grant, idle or parity pulse
  task automatic wait_on(input int s);
    int n;
    logic hit;
    hit = 1'b0;
    for (n = 0; n < 400 && !hit; n++) begin
      @(posedge i_sys_clk);
      hit = (s == 0) ? o_host_strobe === 1'b1 :
        (s == 1) ? o_access_grant === 1'b1 :
        (s == 2) ? o_idle === 1'b1 : o_descriptor_parity_error === 1'b1;
    end
    chk({35'h0, hit}, 36'h1);
  endtask

  // Wait until the memory port has been quiet for 8 cycles
  task automatic settle();
    int q = 0;
    for (int n = 0; n < 400 && q < 8; n++) begin
      @(posedge i_sys_clk);
      q = (o_mux_request === 1'b0) ? q + 1 : 0;
    end
  endtask

  task automatic peer(input logic [35:0] w);
    i_periph_data <= w;
    i_peer_strobe <= 1'b1;
    @(posedge i_sys_clk);
    i_peer_strobe <= 1'b0;
    i_periph_data <= ~w;
  endtask

  task automatic start_channel(input logic dir, input logic [17:0] ptr);
    i_dir_to_periph <= dir;
    i_access_req <= 1'b1;
    wait_on(1);
    peer({18'h00000, ptr});
  endtask

  task automatic close_channel();
    i_access_req <= 1'b0;
    repeat (12) @(posedge i_sys_clk);
  endtask

  // Cycle ceiling
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
  end

  // ------
  // Tests
  // ------
  initial begin
    i_mem.bad_addr = 18'h3FFFF;
    repeat (2) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    @(posedge i_sys_clk);
    chk({35'h0, o_idle}, 36'h1);
    chk({35'h0, o_access_grant}, 36'h0);
    // Inbound: jump, two stored words, one discarded, then stop
    i_mem.mem[8'h10] = {18'h00000, 18'h00020};
    i_mem.mem[8'h20] = {18'h3FFFE, 18'h00030};
    i_mem.mem[8'h21] = {18'h3FFFF, 18'h00000};
    i_mem.mem[8'h22] = 36'h000000000;
    i_mem.mem[8'h00] = 36'h0000000AA;
    start_channel(1'b0, 18'h00010);
    for (int k = 0; k < 3; k++) begin
      settle();
      peer(36'h123456780 + 36'(k));
      wait_on(0);
      if (k == 0) chk({28'h0, o_first_pointer}, 36'h8);
    end
    wait_on(2);
    chk({35'h0, o_access_grant}, 36'h0);
    chk(i_mem.mem[8'h30], 36'h123456780);
    chk(i_mem.mem[8'h31], 36'h123456781);
    chk(i_mem.mem[8'h00], 36'h0000000AA);
    close_channel();
    // Outbound: two words, then a descriptor with bad parity
    i_mem.mem[8'h50] = {18'h3FFFE, 18'h00040};
    i_mem.mem[8'h40] = 36'h0F0F0F0F0;
    i_mem.mem[8'h41] = 36'h5A5A5A5A5;
    i_mem.mem[8'h51] = {18'h3FFFF, 18'h00060};
    i_mem.bad_addr = 18'h00051;
    start_channel(1'b1, 18'h00050);
    wait_on(0);
    chk(o_periph_data, 36'h0F0F0F0F0);
    peer(36'h000000000);
    wait_on(0);
    chk(o_periph_data, 36'h5A5A5A5A5);
    wait_on(3);
    wait_on(2);
    chk({35'h0, o_access_grant}, 36'h0);
    close_channel();
    // Channel reset while the bus is held
    i_access_req <= 1'b1;
    wait_on(1);
    i_chan_reset <= 1'b1;
    @(posedge i_sys_clk);
    i_chan_reset <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    chk({35'h0, o_idle}, 36'h1);
    chk({35'h0, o_access_grant}, 36'h0);
    close_channel();
    test_done();
  end
endmodule

bind descriptor_channel_sequencer descriptor_channel_sequencer_props i_props (.*);
